// ==== core/tmc_timer.sv ====
// How it works
// RULE1 - Compare counter with both compare values continuously
// RULE2 - Compare flag sets one tick after equality
// RULE3 - Enabled flag requests interrupt; acknowledge clears it
// RULE4 - Writing one clears flag; zero leaves it
// RULE5 - PWM modes buffer compare; load at bottom
// RULE6 - Writes hit buffer or active register directly
// RULE7 - Force strobe acts on output, no flag
// RULE8 - Counter write blocks matches in next tick
// RULE9 - Waveform output keeps value across mode change
// RULE10 - Output mode change acts at next match
// RULE11 - Nonzero output mode overrides port data
// RULE12 - Pin driven only when direction is output
// RULE13 - Output mode zero leaves waveform output alone
// RULE14 - Normal mode counts up, wraps FF to 00
// RULE15 - Normal mode overflow flag set at zero
// RULE16 - Clear-on-match mode clears counter at compare A
// RULE17 - Compare A below counter means wrap first
// RULE18 - Toggle mode inverts output A each match
// RULE19 - Toggle frequency set by prescale and compare A
// RULE20 - Clear-on-match overflow flag set at MAX rollover
// RULE21 - Software avoids writing counter equal to compare
// RULE22 - Software sets output state before enabling pin
// RULE23 - Clock select zero stops tick; writes win
// RULE24 - Hardware set beats simultaneous software clear
// RULE25 - Force strobe bits always read zero
//
// The AXI4-Lite interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "tmc_defs.svh"

module tmc_timer
    import tmc_pkg::*;
#(
    parameter int ADDR_W = 5
)
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // AXI4-Lite write channels
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read channels
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Interrupt request and execution acknowledge, bit order overflow, A, B
    output logic [2:0] irq_req,
    input wire logic [2:0] irq_ack,
    // Port pins
    output logic pin_a_out,
    output logic pin_a_oe,
    output logic pin_b_out,
    output logic pin_b_oe
);

    tmc_ctrl_t ctrl;
    tmc_pin_t pins;
    logic [7:0] counter_value;
    logic [7:0] compare_a_value;
    logic [7:0] compare_b_value;
    logic [7:0] compare_a_buf;
    logic [7:0] compare_b_buf;
    logic overflow_flag;
    logic compare_a_flag;
    logic compare_b_flag;
    logic [2:0] irq_en;
    logic wave_out_a;
    logic wave_out_b;
    logic block_pending;
    logic [9:0] presc;
    logic [9:0] div_m1;
    logic timer_tick;
    logic pwm_mode;
    logic match_a;
    logic match_b;
    logic aw_held;
    logic w_held;
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic wr_fire;
    logic wr_ctrl;
    logic wr_count;
    logic wr_cmpa;
    logic wr_cmpb;
    logic wr_flags;
    logic wr_irqen;
    logic wr_pin;
    logic wr_mapped;
    logic [15:0] ctrl_merged;
    tmc_ctrl_t next_ctrl;
    logic force_a;
    logic force_b;
    logic set_ovf;
    logic set_a;
    logic set_b;
    logic clr_ovf;
    logic clr_a;
    logic clr_b;
    logic [31:0] rd_word;
    logic rd_ok;

    // Apply one compare output action to the waveform bit
    function automatic logic wave_action(input tmc_com_t com, input logic cur);
        case (com)
            TMC_COM_TOGGLE: wave_action = ~cur;
            TMC_COM_CLEAR: wave_action = 1'b0;
            TMC_COM_SET: wave_action = 1'b1;
            default: wave_action = cur;
        endcase
    endfunction

    // Write path: address and data are held separately, then joined
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign wr_fire = aw_held && w_held && !s_axi_bvalid;

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            else if (wr_fire)
                aw_held <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            else if (wr_fire)
                w_held <= 1'b0;
        end
    end

    // Write decode; byte lane 0 carries every 8-bit register
    assign wr_ctrl = wr_fire && aw_addr == `TMC_OFS_CTRL;
    assign wr_count = wr_fire && aw_addr == `TMC_OFS_COUNT && w_strb[0];
    assign wr_cmpa = wr_fire && aw_addr == `TMC_OFS_CMPA && w_strb[0];
    assign wr_cmpb = wr_fire && aw_addr == `TMC_OFS_CMPB && w_strb[0];
    assign wr_flags = wr_fire && aw_addr == `TMC_OFS_FLAGS && w_strb[0];
    assign wr_irqen = wr_fire && aw_addr == `TMC_OFS_IRQEN && w_strb[0];
    assign wr_pin = wr_fire && aw_addr == `TMC_OFS_PINCFG && w_strb[0];
    assign wr_mapped = aw_addr == `TMC_OFS_CTRL || aw_addr == `TMC_OFS_COUNT
        || aw_addr == `TMC_OFS_CMPA || aw_addr == `TMC_OFS_CMPB
        || aw_addr == `TMC_OFS_FLAGS || aw_addr == `TMC_OFS_IRQEN
        || aw_addr == `TMC_OFS_PINCFG;

    // Write response, unmapped addresses answer SLVERR
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `TMC_RESP_OKAY;
        end
        else if (wr_fire)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_mapped ? `TMC_RESP_OKAY : `TMC_RESP_SLVERR;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // Control merge by byte lane; the new output mode counts at once
    assign ctrl_merged = {w_strb[1] ? w_data[15:8] : {6'h00, ctrl[9:8]},
        w_strb[0] ? w_data[7:0] : ctrl[7:0]};
    assign next_ctrl = wr_ctrl ? tmc_ctrl_t'(ctrl_merged[9:0]) : ctrl;

    always_ff @(posedge mclk)
    begin
        if (rst)
            ctrl <= tmc_ctrl_t'(`TMC_RST_CTRL);
        else
            ctrl <= next_ctrl;
    end

    // Small registers: interrupt enables and port pin settings
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            irq_en <= 3'h0;
            pins <= 4'h0;
        end
        else
        begin
            if (wr_irqen)
                irq_en <= w_data[2:0];
            if (wr_pin)
                pins <= w_data[3:0];
        end
    end

    // Prescaler; divide table gives the toggle rate of clear-on-match mode
    // RULE19 prescale selection
    always_comb
    begin
        case (ctrl.clock_select_field)
            3'h1: div_m1 = `TMC_DIV_1;
            3'h2: div_m1 = `TMC_DIV_8;
            3'h3: div_m1 = `TMC_DIV_32;
            3'h4: div_m1 = `TMC_DIV_64;
            3'h5: div_m1 = `TMC_DIV_128;
            3'h6: div_m1 = `TMC_DIV_256;
            default: div_m1 = `TMC_DIV_1024;
        endcase
    end

    // RULE23 stopped tick
    assign timer_tick = ctrl.clock_select_field != 3'h0 && presc == div_m1;

    always_ff @(posedge mclk)
    begin
        if (rst || timer_tick || ctrl.clock_select_field == 3'h0)
            presc <= 10'h000;
        else
            presc <= presc + 10'h001;
    end

    // Odd mode codes are the PWM modes
    assign pwm_mode = ctrl.waveform_mode_select[0];

    // RULE1 comparators
    // RULE8 blocked matches
    assign match_a = counter_value == compare_a_value && !block_pending;
    assign match_b = counter_value == compare_b_value && !block_pending;

    // A counter write arms the block until the next tick, even when stopped
    // RULE8 block window
    always_ff @(posedge mclk)
    begin
        if (rst)
            block_pending <= 1'b0;
        else if (wr_count)
            block_pending <= 1'b1;
        else if (timer_tick)
            block_pending <= 1'b0;
    end

    // Counter; a CPU write beats clear and count
    // RULE23 write priority
    // RULE14 normal wrap
    // RULE16 clear at compare A
    // RULE17 missed top wraps
    always_ff @(posedge mclk)
    begin
        if (rst)
            counter_value <= `TMC_RST_BYTE;
        else if (wr_count)
            counter_value <= w_data[7:0];
        else if (timer_tick)
        begin
            if (ctrl.waveform_mode_select == `TMC_WGM_CTC && match_a)
                counter_value <= `TMC_BOTTOM;
            else
                counter_value <= counter_value + 8'h01;
        end
    end

    // Compare registers; PWM loads the buffer and transfers at bottom
    // RULE5 buffer transfer
    // RULE6 access routing
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            compare_a_buf <= `TMC_RST_BYTE;
            compare_b_buf <= `TMC_RST_BYTE;
            compare_a_value <= `TMC_RST_BYTE;
            compare_b_value <= `TMC_RST_BYTE;
        end
        else
        begin
            if (wr_cmpa)
                compare_a_buf <= w_data[7:0];
            if (wr_cmpb)
                compare_b_buf <= w_data[7:0];
            if (!pwm_mode)
            begin
                if (wr_cmpa)
                    compare_a_value <= w_data[7:0];
                if (wr_cmpb)
                    compare_b_value <= w_data[7:0];
            end
            else if (timer_tick && counter_value == `TMC_MAX && !wr_count)
            begin
                compare_a_value <= compare_a_buf;
                compare_b_value <= compare_b_buf;
            end
        end
    end

    // Flag set and clear terms
    // RULE2 flag one tick later
    // RULE15 overflow at zero
    // RULE20 overflow at rollover
    assign set_a = timer_tick && match_a;
    assign set_b = timer_tick && match_b;
    assign set_ovf = timer_tick && counter_value == `TMC_MAX && !wr_count;
    // RULE4 write one clears
    // RULE3 cleared on execution
    assign clr_a = (wr_flags && w_data[`TMC_FLAG_CMPA]) || irq_ack[`TMC_FLAG_CMPA];
    assign clr_b = (wr_flags && w_data[`TMC_FLAG_CMPB]) || irq_ack[`TMC_FLAG_CMPB];
    assign clr_ovf = (wr_flags && w_data[`TMC_FLAG_OVF]) || irq_ack[`TMC_FLAG_OVF];

    // Sticky flags; a set in the clearing cycle is kept
    // RULE24 set beats clear
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            overflow_flag <= 1'b0;
            compare_a_flag <= 1'b0;
            compare_b_flag <= 1'b0;
        end
        else
        begin
            overflow_flag <= set_ovf || (overflow_flag && !clr_ovf);
            compare_a_flag <= set_a || (compare_a_flag && !clr_a);
            compare_b_flag <= set_b || (compare_b_flag && !clr_b);
        end
    end

    // RULE3 interrupt request
    assign irq_req = {compare_b_flag, compare_a_flag, overflow_flag} & irq_en;

    // Force strobes exist only as write pulses, never stored
    // RULE7 force only outside PWM
    assign force_a = wr_ctrl && w_strb[1] && w_data[`TMC_FORCE_A_BIT] && !pwm_mode;
    assign force_b = wr_ctrl && w_strb[1] && w_data[`TMC_FORCE_B_BIT] && !pwm_mode;

    // Waveform bits change only by actions, so a mode change keeps them
    // RULE9 value retained
    // RULE10 unbuffered output mode
    // RULE13 zero mode no action
    // RULE18 toggle on match
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            wave_out_a <= 1'b0;
            wave_out_b <= 1'b0;
        end
        else
        begin
            if (force_a || (set_a && !pwm_mode))
                wave_out_a <= wave_action(next_ctrl.compare_output_mode_a, wave_out_a);
            if (force_b || (set_b && !pwm_mode))
                wave_out_b <= wave_action(next_ctrl.compare_output_mode_b, wave_out_b);
        end
    end

    // Pin drivers, registered so the pads see clean levels
    // RULE11 port override
    // RULE12 direction gate
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            pin_a_out <= 1'b0;
            pin_a_oe <= 1'b0;
            pin_b_out <= 1'b0;
            pin_b_oe <= 1'b0;
        end
        else
        begin
            pin_a_out <= ctrl.compare_output_mode_a != TMC_COM_NONE ? wave_out_a : pins.data_a;
            pin_a_oe <= pins.dir_a;
            pin_b_out <= ctrl.compare_output_mode_b != TMC_COM_NONE ? wave_out_b : pins.data_b;
            pin_b_oe <= pins.dir_b;
        end
    end

    // Read mux; the force bits are absent, so they read zero
    // RULE25 force reads zero
    // RULE6 read routing
    always_comb
    begin
        rd_word = 32'h0000_0000;
        rd_ok = 1'b1;
        case (s_axi_araddr)
            `TMC_OFS_CTRL: rd_word = {22'h00_0000, ctrl};
            `TMC_OFS_COUNT: rd_word = {24'h00_0000, counter_value};
            `TMC_OFS_CMPA: rd_word = {24'h00_0000, pwm_mode ? compare_a_buf : compare_a_value};
            `TMC_OFS_CMPB: rd_word = {24'h00_0000, pwm_mode ? compare_b_buf : compare_b_value};
            `TMC_OFS_FLAGS: rd_word = {29'h0000_0000, compare_b_flag, compare_a_flag,
                overflow_flag};
            `TMC_OFS_IRQEN: rd_word = {29'h0000_0000, irq_en};
            `TMC_OFS_PINCFG: rd_word = {28'h000_0000, pins};
            default: rd_ok = 1'b0;
        endcase
    end

    // Read channel answers one cycle after the address is taken
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `TMC_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_ok ? `TMC_RESP_OKAY : `TMC_RESP_SLVERR;
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // Checks beside the logic
    sequence s_count_write;
        wr_count;
    endsequence
    sequence s_no_match;
        !match_a && !match_b;
    endsequence

    property p_block_after_write;
        @(posedge mclk) disable iff (rst) s_count_write |=> s_no_match;
    endproperty
    a_block_after_write: assert property (p_block_after_write) // RULE8
        else $error("match seen right after counter write");

    property p_flag_next_tick;
        @(posedge mclk) disable iff (rst) timer_tick && match_a |=> compare_a_flag;
    endproperty
    a_flag_next_tick: assert property (p_flag_next_tick) // RULE2
        else $error("compare A flag missing after match tick");

    property p_normal_wrap;
        @(posedge mclk) disable iff (rst)
        ctrl.waveform_mode_select == `TMC_WGM_NORMAL && timer_tick && !wr_count
        && counter_value == `TMC_MAX |=> counter_value == `TMC_BOTTOM && overflow_flag;
    endproperty
    a_normal_wrap: assert property (p_normal_wrap) // RULE15
        else $error("normal mode wrap or overflow wrong");

    property p_ctc_clear;
        @(posedge mclk) disable iff (rst)
        ctrl.waveform_mode_select == `TMC_WGM_CTC && timer_tick && match_a && !wr_count
        |=> counter_value == `TMC_BOTTOM;
    endproperty
    a_ctc_clear: assert property (p_ctc_clear) // RULE16
        else $error("counter not cleared on compare A");

    property p_set_wins;
        @(posedge mclk) disable iff (rst) set_b && clr_b |=> compare_b_flag;
    endproperty
    a_set_wins: assert property (p_set_wins) // RULE24
        else $error("flag lost to simultaneous clear");

    property p_w1c;
        @(posedge mclk) disable iff (rst)
        wr_flags && w_data[`TMC_FLAG_OVF] && !set_ovf |=> !overflow_flag;
    endproperty
    a_w1c: assert property (p_w1c) // RULE4
        else $error("overflow flag not cleared by one");

    property p_force_no_flag;
        @(posedge mclk) disable iff (rst) force_a && !set_a && !compare_a_flag && !timer_tick
        |=> !compare_a_flag && $stable(counter_value);
    endproperty
    a_force_no_flag: assert property (p_force_no_flag) // RULE7
        else $error("force set the flag or moved the counter");

    property p_toggle;
        @(posedge mclk) disable iff (rst)
        ctrl.waveform_mode_select == `TMC_WGM_CTC && set_a && !wr_ctrl
        && ctrl.compare_output_mode_a == TMC_COM_TOGGLE |=> wave_out_a != $past(wave_out_a);
    endproperty
    a_toggle: assert property (p_toggle) // RULE18
        else $error("output A did not toggle");

    property p_mode_zero;
        @(posedge mclk) disable iff (rst)
        set_b && !wr_ctrl && ctrl.compare_output_mode_b == TMC_COM_NONE |=> $stable(wave_out_b);
    endproperty
    a_mode_zero: assert property (p_mode_zero) // RULE13
        else $error("output B changed with mode zero");

    property p_pin_override;
        @(posedge mclk) disable iff (rst)
        ctrl.compare_output_mode_a != TMC_COM_NONE ##1 $stable(ctrl)
        |-> pin_a_out == $past(wave_out_a) && pin_a_oe == $past(pins.dir_a);
    endproperty
    a_pin_override: assert property (p_pin_override) // RULE11
        else $error("pin A not driven from waveform output");

    property p_irq;
        @(posedge mclk) disable iff (rst) compare_a_flag && irq_en[`TMC_FLAG_CMPA] |-> irq_req[1];
    endproperty
    a_irq: assert property (p_irq) // RULE3
        else $error("interrupt request missing");

    property p_stopped;
        @(posedge mclk) disable iff (rst)
        ctrl.clock_select_field == 3'h0 && !wr_count |=> $stable(counter_value);
    endproperty
    a_stopped: assert property (p_stopped) // RULE23
        else $error("counter moved while stopped");

endmodule // tmc_timer

`default_nettype wire

// ==== core/tmc_defs.svh ====
`ifndef TMC_DEFS_SVH
`define TMC_DEFS_SVH

// Register byte offsets
`define TMC_OFS_CTRL 5'h00
`define TMC_OFS_COUNT 5'h04
`define TMC_OFS_CMPA 5'h08
`define TMC_OFS_CMPB 5'h0C
`define TMC_OFS_FLAGS 5'h10
`define TMC_OFS_IRQEN 5'h14
`define TMC_OFS_PINCFG 5'h18

// Control register fields
`define TMC_CTRL_W 10
`define TMC_FORCE_A_BIT 10
`define TMC_FORCE_B_BIT 11

// Flag, enable and pin configuration bit positions
`define TMC_FLAG_OVF 0
`define TMC_FLAG_CMPA 1
`define TMC_FLAG_CMPB 2
`define TMC_PIN_DATA_A 0
`define TMC_PIN_DIR_A 1
`define TMC_PIN_DATA_B 2
`define TMC_PIN_DIR_B 3

// Waveform mode codes
`define TMC_WGM_NORMAL 3'h0
`define TMC_WGM_CTC 3'h2

// Counter extremes
`define TMC_BOTTOM 8'h00
`define TMC_MAX 8'hFF

// Reset values
`define TMC_RST_CTRL 10'h000
`define TMC_RST_BYTE 8'h00

// Prescale divide-by-minus-one per clock select code 1..7 (1,8,32,64,128,256,1024)
`define TMC_DIV_1 10'h000
`define TMC_DIV_8 10'h007
`define TMC_DIV_32 10'h01F
`define TMC_DIV_64 10'h03F
`define TMC_DIV_128 10'h07F
`define TMC_DIV_256 10'h0FF
`define TMC_DIV_1024 10'h3FF

// Bus responses
`define TMC_RESP_OKAY 2'h0
`define TMC_RESP_SLVERR 2'h2

`endif

// ==== core/tmc_pkg.sv ====
package tmc_pkg;

    // Compare output action taken on a match or a force
    typedef enum logic [1:0] {TMC_COM_NONE, TMC_COM_TOGGLE, TMC_COM_CLEAR, TMC_COM_SET} tmc_com_t;

    // Stored control settings, low bits of the control register
    typedef struct packed {
        logic [2:0] clock_select_field;
        tmc_com_t compare_output_mode_b;
        tmc_com_t compare_output_mode_a;
        logic [2:0] waveform_mode_select;
    } tmc_ctrl_t;

    // Port pin settings
    typedef struct packed {
        logic dir_b;
        logic data_b;
        logic dir_a;
        logic data_a;
    } tmc_pin_t;

endpackage

// ==== tb/tmc_pin_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module tmc_pin_model
(
    // Pin drivers from the timer
    input wire logic pin_a_out,
    input wire logic pin_a_oe,
    input wire logic pin_b_out,
    input wire logic pin_b_oe,
    // Resolved pad levels
    output logic pad_a,
    output logic pad_b
);
    // pad pull-up
    // A released pad goes to the pull-up, never keeps the last driven level
    assign pad_a = pin_a_oe ? pin_a_out : 1'h1;
    assign pad_b = pin_b_oe ? pin_b_out : 1'h1;
endmodule // tmc_pin_model

`default_nettype wire

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "tmc_defs.svh"

module tb_top;
    logic mclk = 1'h0;
    logic rst = 1'h1;
    logic [4:0] s_axi_awaddr = 5'h00;
    logic [4:0] s_axi_araddr = 5'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic s_axi_awvalid = 1'h0;
    logic s_axi_wvalid = 1'h0;
    logic s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0;
    logic s_axi_rready = 1'h0;
    logic [2:0] irq_ack = 3'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr;
    logic [31:0] s_axi_rdata, rv;
    logic [2:0] irq_req;
    logic pin_a_out, pin_a_oe, pin_b_out, pin_b_oe, pad_a, pad_b;
    int miscompares = 0;
    int n_checks = 0;
    int n;

    tmc_timer tmc_timer_i
    (
        .mclk(mclk), .rst(rst), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .irq_req(irq_req), .irq_ack(irq_ack), .pin_a_out(pin_a_out), .pin_a_oe(pin_a_oe),
        .pin_b_out(pin_b_out), .pin_b_oe(pin_b_oe)
    );

    tmc_pin_model tmc_pin_model_i
    (
        .pin_a_out(pin_a_out), .pin_a_oe(pin_a_oe), .pin_b_out(pin_b_out),
        .pin_b_oe(pin_b_oe), .pad_a(pad_a), .pad_b(pad_b)
    );

    // 50 MHz clock
    always #10 mclk = ~mclk;

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        begin
            n_checks++;
            if (seen !== exp)
            begin
                miscompares++;
                $display("unexpected %s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask

    // Ready is sampled at the falling edge, since inputs only move after rising ones
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic ah, wh, bh;
        begin
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            s_axi_awvalid <= 1'h1;
            s_axi_wvalid <= 1'h1;
            s_axi_bready <= 1'h1;
            bh = 1'h0;
            while (!bh)
            begin
                @(negedge mclk);
                ah = s_axi_awready & s_axi_awvalid;
                wh = s_axi_wready & s_axi_wvalid;
                bh = s_axi_bvalid;
                rr = s_axi_bresp;
                @(posedge mclk);
                if (ah) s_axi_awvalid <= 1'h0;
                if (wh) s_axi_wvalid <= 1'h0;
            end
            s_axi_bready <= 1'h0;
            @(posedge mclk);
        end
    endtask

    task automatic rd(input logic [4:0] a);
        logic ah, dh;
        begin
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'h1;
            s_axi_rready <= 1'h1;
            dh = 1'h0;
            while (!dh)
            begin
                @(negedge mclk);
                ah = s_axi_arready & s_axi_arvalid;
                dh = s_axi_rvalid;
                rv = s_axi_rdata;
                rr = s_axi_rresp;
                @(posedge mclk);
                if (ah) s_axi_arvalid <= 1'h0;
            end
            s_axi_rready <= 1'h0;
            @(posedge mclk);
        end
    endtask

    task automatic rdc(input logic [4:0] a, input string nm, input logic [31:0] exp);
        begin
            rd(a);
            chk(nm, rv, exp);
        end
    endtask

    // Cycles between two changes of output A
    task automatic period(output int c);
        logic p;
        begin
            @(negedge mclk);
            p = pin_a_out;
            while (pin_a_out === p) @(negedge mclk);
            p = pin_a_out;
            c = 0;
            while (pin_a_out === p)
            begin
                @(negedge mclk);
                c++;
            end
            @(posedge mclk);
        end
    endtask

    task automatic final_report;
        begin
            $display("checks %0d miscompares %0d", n_checks, miscompares);
            if (miscompares == 0 && n_checks > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask

    // Main sequence
    initial
    begin
        repeat (6) @(posedge mclk);
        rst <= 1'h0;
        @(posedge mclk);
        rdc(`TMC_OFS_CTRL, "ctrl", 32'h0000_0000);
        rd(5'h1C);
        chk("unmapped resp", 32'(rr), 32'(`TMC_RESP_SLVERR));
        wr(5'h1C, 32'h0000_0000);
        chk("unmapped bresp", 32'(rr), 32'(`TMC_RESP_SLVERR));
        $display("test registers done");
        // Stopped timer, output set up by force before the pin is enabled
        wr(`TMC_OFS_PINCFG, 32'h0000_0000);
        wr(`TMC_OFS_CTRL, 32'h0000_0418);
        @(negedge mclk);
        chk("pin a", 32'(pin_a_out), 32'h0000_0001);
        chk("pad a", 32'(pad_a), 32'h0000_0001);
        @(posedge mclk);
        rdc(`TMC_OFS_FLAGS, "flags", 32'h0000_0000);
        rdc(`TMC_OFS_CTRL, "ctrl", 32'h0000_0018);
        wr(`TMC_OFS_CTRL, 32'h0000_0410);
        @(negedge mclk);
        chk("pin a", 32'(pin_a_out), 32'h0000_0000);
        chk("pad a idle", 32'(pad_a), 32'h0000_0001);
        @(posedge mclk);
        wr(`TMC_OFS_PINCFG, 32'h0000_0003);
        @(negedge mclk);
        chk("pad a", 32'(pad_a), 32'h0000_0000);
        chk("oe a", 32'(pin_a_oe), 32'h0000_0001);
        chk("pad b", 32'(pad_b), 32'h0000_0001);
        @(posedge mclk);
        $display("test force done");
        // Counter written equal to compare B, then started
        wr(`TMC_OFS_CMPB, 32'h0000_0005);
        wr(`TMC_OFS_COUNT, 32'h0000_0005);
        wr(`TMC_OFS_CTRL, 32'h0000_0080);
        rdc(`TMC_OFS_FLAGS, "flags", 32'h0000_0000);
        repeat (300) @(posedge mclk);
        rdc(`TMC_OFS_FLAGS, "flags", 32'h0000_0007);
        wr(`TMC_OFS_CTRL, 32'h0000_0000);
        wr(`TMC_OFS_IRQEN, 32'h0000_0001);
        @(negedge mclk);
        chk("irq", 32'(irq_req), 32'h0000_0001);
        @(posedge mclk);
        irq_ack <= 3'h1;
        @(posedge mclk);
        irq_ack <= 3'h0;
        @(posedge mclk);
        rdc(`TMC_OFS_FLAGS, "flags", 32'h0000_0006);
        wr(`TMC_OFS_FLAGS, 32'h0000_0003);
        rdc(`TMC_OFS_FLAGS, "flags", 32'h0000_0004);
        $display("test flags done");
        // Toggle on compare A at two prescale settings
        wr(`TMC_OFS_IRQEN, 32'h0000_0000);
        wr(`TMC_OFS_CMPA, 32'h0000_0003);
        wr(`TMC_OFS_COUNT, 32'h0000_0000);
        wr(`TMC_OFS_CTRL, 32'h0000_008A);
        period(n);
        chk("half period", 32'(n), 32'h0000_0004);
        wr(`TMC_OFS_CTRL, 32'h0000_010A);
        period(n);
        period(n);
        chk("half period", 32'(n), 32'h0000_0020);
        $display("test toggle done");
        // PWM code holds a compare write in the buffer until the wrap
        wr(`TMC_OFS_CTRL, 32'h0000_0001);
        wr(`TMC_OFS_CMPA, 32'h0000_0007);
        rdc(`TMC_OFS_CMPA, "cmpa buffer", 32'h0000_0007);
        wr(`TMC_OFS_CTRL, 32'h0000_0000);
        rdc(`TMC_OFS_CMPA, "cmpa active", 32'h0000_0003);
        wr(`TMC_OFS_CTRL, 32'h0000_0081);
        repeat (300) @(posedge mclk);
        wr(`TMC_OFS_CTRL, 32'h0000_0000);
        rdc(`TMC_OFS_CMPA, "cmpa loaded", 32'h0000_0007);
        $display("test buffer done");
        final_report;
    end

    // Watchdog, well beyond the thousand or so cycles the tests need
    initial
    begin
        repeat (20000) @(posedge mclk);
        miscompares++;
        final_report;
    end
endmodule // tb_top

`default_nettype wire
